//--- src/lcdcd_decoder.v
`include "lcdcd_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module lcdcd_decoder #(
  parameter IS_SLAVE  = 0,         // passive slave variant, duty command ignored
  parameter RESET_CYC = `LCDCD_RESET_CYC
) (
  input  wire       i_clk_sys,                 // system clock
  input  wire       i_sys_rst,                 // sync reset, active high
  input  wire       i_hardware_reset_pin,      // hardware reset level, active high
  input  wire       i_command_data_select,     // 0 command/status, 1 display data
  input  wire       i_rd,                      // read strobe, one cycle pulse
  input  wire       i_wr,                      // write strobe, one cycle pulse
  input  wire [7:0] i_data,                    // write data bus
  input  wire       i_ext_clk,                 // external oscillator clock level
  input  wire       i_frame_alternation_input, // external frame signal (slave)
  output reg  [7:0] o_data,                    // read data
  output reg        o_data_valid,              // read data valid pulse
  output reg        o_wr_ready,                // write strobe will be taken
  output reg        o_seg_dir_normal,          // 1: column n drives segment n
  output reg        o_display_on,              // display on setting
  output reg        o_static_drive,            // static drive setting
  output reg        o_duty_high,               // 1: larger duty selected
  output reg        o_power_save,              // power save state
  output reg        o_osc_out_oe_n,            // oscillator output enable, low drives
  output reg        o_osc_out,                 // oscillator output level
  output reg  [4:0] o_start_line,              // display start line
  output reg  [1:0] o_page                     // page address
);
  // state machine codes
  localparam ST_IDLE  = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_RESET = 2'd2;
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [7:0] rst_cnt_reg;
  reg  [6:0] col_reg;
  reg  [6:0] col_saved_reg;
  reg        rmw_reg;
  reg  [7:0] latch_reg;
  reg  [7:0] ram [0:4*80-1];
  reg  [8:0] cmd_reg;
  reg        cmd_take;
  reg        reload_reg;
  reg        hw_rst_reg;
  reg  [4:0] q_cnt_reg;   // bytes in the fifo, output word included
  // fifo between host bus and command engine
  wire       f_in_ready;
  wire       f_out_valid;
  wire [8:0] f_out_data;
  wire       f_take = (state_reg == ST_IDLE) && f_out_valid;
  // a byte still crossing the fifo already counts as busy, so no poll slips between
  wire       busy   = (state_reg != ST_IDLE) || (q_cnt_reg != 5'h00);
  wire       resetting = (state_reg == ST_RESET);
  lcdcd_fifo #(
    .WIDTH(9),
    .DEPTH(16),
    .AW   (4)
  ) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_sys_rst  (i_sys_rst),
    .i_in_valid (i_wr),
    .o_in_ready (f_in_ready),
    .i_in_data  ({i_command_data_select, i_data}),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_take),
    .o_out_data (f_out_data)
  );
  // column advance saturating at the stop address
  function [6:0] col_inc;
    input [6:0] c;
    begin
      col_inc = (c == `LCDCD_COL_STOP) ? c : c + 7'h01;
    end
  endfunction
  function [8:0] ram_addr;
    input [1:0] p;
    input [6:0] c;
    begin
      ram_addr = ({7'h00, p} * 9'd80) + {2'b00, c};
    end
  endfunction
  // state sequencing, reset wins over everything
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (f_take) state_next = ST_EXEC;
      ST_EXEC:  state_next = ST_IDLE;
      ST_RESET: if (rst_cnt_reg == 8'h00 && !hw_rst_reg) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end
  always @*
  begin
    cmd_take = f_take;
  end
  // main engine: one queued byte per two cycles
  always @(posedge i_clk_sys)
  begin
    hw_rst_reg <= i_hardware_reset_pin;
    if (i_sys_rst || hw_rst_reg)
    begin
      state_reg        <= ST_RESET;
      rst_cnt_reg      <= RESET_CYC[7:0];
      col_reg          <= `LCDCD_RST_COL;
      col_saved_reg    <= `LCDCD_RST_COL;
      rmw_reg          <= 1'b0;
      latch_reg        <= 8'h00;
      cmd_reg          <= 9'h000;
      reload_reg       <= 1'b0;
      o_seg_dir_normal <= 1'b1;
      o_display_on     <= 1'b0;
      o_static_drive   <= 1'b0;
      o_duty_high      <= 1'b1;
      o_start_line     <= `LCDCD_RST_LINE;
      o_page           <= `LCDCD_RST_PAGE;
    end
    else
    begin
      state_reg  <= state_next;
      reload_reg <= 1'b0;
      if (state_reg == ST_RESET && rst_cnt_reg != 8'h00)
        rst_cnt_reg <= rst_cnt_reg - 8'h01;
      if (cmd_take)
        cmd_reg <= f_out_data;
      if (state_reg == ST_EXEC)
      begin
        if (cmd_reg[8])
        begin
          if (col_reg != `LCDCD_COL_STOP)                 // column 80 has no cell, must not hit next page
            ram[ram_addr(o_page, col_reg)] <= cmd_reg[7:0];
          col_reg <= col_inc(col_reg);
        end
        else if ((cmd_reg[7:0] & `LCDCD_OP_DISP_MASK) == `LCDCD_OP_DISP)
          o_display_on <= cmd_reg[0];
        else if ((cmd_reg[7:0] & `LCDCD_OP_DISP_MASK) == `LCDCD_OP_DIR)
          o_seg_dir_normal <= !cmd_reg[0];
        else if ((cmd_reg[7:0] & `LCDCD_OP_DISP_MASK) == `LCDCD_OP_STATIC)
          o_static_drive <= cmd_reg[0];
        else if ((cmd_reg[7:0] & `LCDCD_OP_DISP_MASK) == `LCDCD_OP_DUTY)
        begin
          if (IS_SLAVE == 0)
            o_duty_high <= cmd_reg[0];
        end
        else if (cmd_reg[7:0] == `LCDCD_OP_RMW)
        begin
          rmw_reg       <= 1'b1;
          col_saved_reg <= col_reg;
        end
        else if (cmd_reg[7:0] == `LCDCD_OP_END)
        begin
          if (rmw_reg)
            col_reg <= col_saved_reg;
          rmw_reg <= 1'b0;
        end
        else if (cmd_reg[7:0] == `LCDCD_OP_RESET)
        begin
          o_start_line <= `LCDCD_RST_LINE;
          o_page       <= `LCDCD_RST_PAGE;
        end
        else if ((cmd_reg[7:0] & `LCDCD_OP_PAGE_MASK) == `LCDCD_OP_PAGE)
          o_page <= cmd_reg[1:0];
        else if ((cmd_reg[7:0] & `LCDCD_OP_LINE_MASK) == `LCDCD_OP_LINE)
          o_start_line <= cmd_reg[4:0];
        else if (cmd_reg[7:0] <= {1'b0, `LCDCD_COL_LAST})
          col_reg <= cmd_reg[6:0];
        // anything else falls through untouched
      end
      // data read: present latch, reload from ram, advance unless in read-modify-write
      if (i_rd && i_command_data_select && !busy)
      begin
        latch_reg  <= (col_reg == `LCDCD_COL_STOP) ? 8'h00 : ram[ram_addr(o_page, col_reg)];
        reload_reg <= 1'b1;
        if (!rmw_reg)
          col_reg <= col_inc(col_reg);
      end
    end
  end
  // read port and derived outputs, all registered
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_data         <= 8'h00;
      o_data_valid   <= 1'b0;
      o_wr_ready     <= 1'b0;
      o_power_save   <= 1'b0;
      o_osc_out_oe_n <= 1'b1;
      o_osc_out      <= 1'b0;
      q_cnt_reg      <= 5'h00;
    end
    else
    begin
      o_data_valid <= i_rd;
      q_cnt_reg    <= q_cnt_reg + {4'h0, (i_wr && f_in_ready)} - {4'h0, f_take};
      o_wr_ready   <= f_in_ready && !resetting;
      if (i_rd && !i_command_data_select)
      begin
        o_data <= 8'h00;
        o_data[`LCDCD_ST_BUSY]  <= busy;
        o_data[`LCDCD_ST_DIR]   <= o_seg_dir_normal;
        o_data[`LCDCD_ST_BLANK] <= !o_display_on;
        o_data[`LCDCD_ST_RESET] <= resetting;
      end
      else if (i_rd)
        o_data <= latch_reg;                       // latch before reload
      o_power_save   <= o_static_drive && !o_display_on;
      o_osc_out_oe_n <= o_power_save;              // float in save
      o_osc_out      <= o_power_save ? 1'b0 : i_ext_clk; // clock input gated
    end
  end
endmodule // lcdcd_decoder
`default_nettype wire

//--- shared/lcdcd_regs.vh
`ifndef LCDCD_REGS_VH
`define LCDCD_REGS_VH
// status byte field positions
`define LCDCD_ST_BUSY        7
`define LCDCD_ST_DIR         6
`define LCDCD_ST_BLANK       5
`define LCDCD_ST_RESET       4
// opcodes and opcode masks
`define LCDCD_OP_DISP_MASK   8'hFE
`define LCDCD_OP_DISP        8'hAE
`define LCDCD_OP_DIR         8'hA0
`define LCDCD_OP_STATIC      8'hA4
`define LCDCD_OP_DUTY        8'hA8
`define LCDCD_OP_RMW         8'hE0
`define LCDCD_OP_END         8'hEE
`define LCDCD_OP_RESET       8'hE2
`define LCDCD_OP_PAGE_MASK   8'hFC
`define LCDCD_OP_PAGE        8'hB8
`define LCDCD_OP_LINE_MASK   8'hE0
`define LCDCD_OP_LINE        8'hC0
`define LCDCD_COL_LAST       7'h4F
`define LCDCD_COL_STOP       7'h50
// reset values
`define LCDCD_RST_PAGE       2'h3
`define LCDCD_RST_LINE       5'h00
`define LCDCD_RST_COL        7'h00
// timing: reset sequence length in ns, cycles at 20 ns
`define LCDCD_RESET_NS       200
`define LCDCD_CLK_NS         20
`define LCDCD_RESET_CYC      ((`LCDCD_RESET_NS + `LCDCD_CLK_NS - 1) / `LCDCD_CLK_NS)
`endif

//--- src/lcdcd_fifo.v
`timescale 1ns/1ps
`default_nettype none
module lcdcd_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk_sys, // clock
  input  wire             i_sys_rst, // sync reset
  input  wire             i_in_valid, // write strobe
  output wire             o_in_ready, // not full
  input  wire [WIDTH-1:0] i_in_data, // write word
  output reg              o_out_valid, // read word valid
  input  wire             i_out_ready, // consumer takes word
  output reg  [WIDTH-1:0] o_out_data // registered read word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire            empty = (wr_ptr_reg == rd_ptr_reg);
  wire            pop   = !empty && (!o_out_valid || i_out_ready);
  assign o_in_ready = !full;
  // storage array, no reset needed on data
  always @(posedge i_clk_sys)
  begin
    if (i_in_valid && !full)
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end
  // pointers and output register
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg  <= {(AW+1){1'b0}};
      rd_ptr_reg  <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (i_in_valid && !full)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
      begin
        o_out_data  <= mem[rd_ptr_reg[AW-1:0]];
        rd_ptr_reg  <= rd_ptr_reg + 1'b1;
        o_out_valid <= 1'b1;
      end
      else if (i_out_ready)
        o_out_valid <= 1'b0;
    end
  end
endmodule // lcdcd_fifo
`default_nettype wire

//--- tb/lcdcd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lcdcd_properties (
  input wire logic       i_clk_sys,             // clock
  input wire logic       i_sys_rst,             // reset
  input wire logic       i_command_data_select, // status or data
  input wire logic       i_rd,                  // read strobe
  input wire logic       i_wr,                  // write strobe
  input wire logic [7:0] o_data,                // read answer
  input wire logic       o_data_valid,          // answer valid
  input wire logic       o_wr_ready,            // write taken
  input wire logic       o_seg_dir_normal,      // direction
  input wire logic       o_display_on,          // display
  input wire logic       o_static_drive,        // static
  input wire logic       o_power_save,          // save state
  input wire logic       o_osc_out_oe_n         // osc enable
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // a status read is a read strobe with the select low
  sequence s_stat;
    i_rd && !i_command_data_select;
  endsequence
  property p_answer; i_rd |=> o_data_valid; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_low; s_stat |=> o_data[3:0] == 4'h0; endproperty
  a_low: assert property (p_low) else $error("status low bits set");
  property p_dir; s_stat |=> o_data[6] == $past(o_seg_dir_normal); endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");
  property p_blank; s_stat |=> o_data[5] == !$past(o_display_on); endproperty
  a_blank: assert property (p_blank) else $error("blank bit wrong");
  property p_busy; s_stat ##1 o_data[4] |-> o_data[7]; endproperty
  a_busy: assert property (p_busy) else $error("reset without busy");
  property p_save_on; o_static_drive && !o_display_on |-> ##[0:2] o_power_save; endproperty
  a_save_on: assert property (p_save_on) else $error("power save not entered");
  property p_save_off; o_display_on || !o_static_drive |-> ##[0:2] !o_power_save; endproperty
  a_save_off: assert property (p_save_off) else $error("power save not left");
  property p_float; o_power_save |-> ##[0:1] o_osc_out_oe_n; endproperty
  a_float: assert property (p_float) else $error("oscillator driven in save");
  property p_ready; $fell(i_sys_rst) |-> !o_wr_ready [*2]; endproperty
  a_ready: assert property (p_ready) else $error("write taken while resetting");
  c_save: cover property (o_power_save);
  c_data_wr: cover property (i_wr && i_command_data_select);
  c_reset_rd: cover property (o_data_valid && o_data[4]);
endmodule // lcdcd_properties
`default_nettype wire

//--- tb/lcdcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host (
  input  wire logic       i_clk_sys,  // clock
  input  wire logic       i_wr_ready, // room for a write
  input  wire logic [7:0] i_data,     // read answer
  output var logic        o_cds,      // command_data_select
  output var logic        o_rd,       // read strobe
  output var logic        o_wr,       // write strobe
  output var logic [7:0]  o_data,     // write byte
  output var logic        o_stuck     // write never taken
);
  initial
  begin
    {o_cds, o_rd, o_wr, o_stuck} = 4'h0;
    o_data = 8'h00;
  end
  // write: hold off while the queue is full, but never forever
  task put(input logic c, input logic [7:0] b);
    int n;
    begin
      for (n = 0; n < 64 && i_wr_ready !== 1'b1; n++)
        @(posedge i_clk_sys);
      o_stuck <= (n == 64);
      @(posedge i_clk_sys);
      o_cds <= c;
      o_wr <= 1'b1;
      o_data <= b;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_data <= ~b; // a released bus must not keep showing the byte
    end
  endtask
  // read: the answer is settled one cycle after the strobe
  task get(input logic c, output logic [7:0] v);
    begin
      @(posedge i_clk_sys);
      o_cds <= c;
      o_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      #1 v = i_data;
    end
  endtask
endmodule // lcdcd_host
`default_nettype wire

//--- tb/lcdcd_driver_command_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_command_decoder_tb;
  logic        i_clk_sys = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        hw_rst    = 1'b1;
  logic        ext_clk   = 1'b0;
  logic        cds, rd, wr, dv, wr_ready, dir, stat, duty, save, oe_n, stuck, disp, osc;
  logic [7:0]  wdat, o_rdat, rdat, r, b0, b1, nb;
  logic [4:0]  line;
  logic [1:0]  page;
  logic [15:0] expq[$];
  int          n_mismatch = 0;
  int          check_count = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) ext_clk <= ~ext_clk;
  lcdcd_decoder #(.IS_SLAVE(0), .RESET_CYC(10)) i_lcdcd_decoder (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_hardware_reset_pin(hw_rst), .i_command_data_select(cds),
    .i_rd(rd), .i_wr(wr), .i_data(wdat), .i_ext_clk(ext_clk), .i_frame_alternation_input(1'b0), .o_data(o_rdat),
    .o_data_valid(dv), .o_wr_ready(wr_ready), .o_seg_dir_normal(dir), .o_display_on(disp), .o_static_drive(stat),
    .o_duty_high(duty), .o_power_save(save), .o_osc_out_oe_n(oe_n), .o_osc_out(osc), .o_start_line(line),
    .o_page(page));
  lcdcd_host i_lcdcd_host (.i_clk_sys(i_clk_sys), .i_wr_ready(wr_ready), .i_data(o_rdat), .o_cds(cds), .o_rd(rd),
    .o_wr(wr), .o_data(wdat), .o_stuck(stuck));
  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    begin
      check_count++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // note the expected answer, masked, then let the host read
  task rd_exp(input logic c, input logic [7:0] e, input logic [7:0] m);
    begin
      expq.push_back({e & m, m});
      i_lcdcd_host.get(c, rdat);
    end
  endtask
  // poll status until busy drops; a stuck device ends the run
  task idle;
    int n;
    begin
      for (n = 0; n < 40; n++)
      begin
        rd_exp(1'b0, 8'h00, 8'h0f);
        if (rdat[7] === 1'b0)
          break;
      end
      if (n == 40)
      begin
        n_mismatch++;
        tally_and_finish();
      end
    end
  endtask
  task send(input logic c, input logic [7:0] b);
    begin
      i_lcdcd_host.put(c, b);
      idle();
      repeat (2) @(posedge i_clk_sys); // mode outputs are registered up to two cycles late
    end
  endtask
  // each read answer is taken against the oldest note
  always @(posedge i_clk_sys)
    if (dv === 1'b1 && expq.size() > 0)
    begin
      chk("read", expq[0][15:8], o_rdat & expq[0][7:0]);
      void'(expq.pop_front());
    end
  always @(posedge stuck)
  begin
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(32'hb2d9));
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    hw_rst <= 1'b0; // power-up reset goes through the pin
    rd_exp(1'b0, 8'hf0, 8'hff);
    idle();
    for (int d = 0; d < 2; d++)
    begin
      send(1'b0, 8'ha0 | 8'(d));
      send(1'b0, 8'hae | 8'(d));
      send(1'b0, 8'ha4 | 8'(d));
      send(1'b0, 8'ha8 | 8'(d));
      rd_exp(1'b0, {1'b0, ~d[0], ~d[0], 5'h00}, 8'hff);
      chk("modes", {4'h0, d[0], d[0], d[0], 1'b0}, {4'h0, disp, stat, duty, save});
    end
    send(1'b0, 8'hae);
    chk("save", 8'h03, {4'h0, osc, dir, save, oe_n});
    send(1'b0, 8'haf);
    chk("save", 8'h00, {5'h00, dir, save, oe_n});
    send(1'b0, 8'hae);
    send(1'b0, 8'ha4);
    chk("save", 8'h00, {6'h00, save, oe_n});
    r = $urandom;
    b0 = $urandom;
    b1 = $urandom;
    nb = $urandom;
    send(1'b0, 8'hb8 | {6'h00, r[1:0]});
    send(1'b0, 8'hc0 | {3'h0, r[6:2]});
    send(1'b0, 8'hf0); // undefined opcode must move nothing
    chk("pos", {1'b0, r[6:0]}, {1'b0, line, page});
    send(1'b0, 8'h4e);
    send(1'b1, b0);
    send(1'b1, b1);
    send(1'b1, nb); // column has stopped at its end
    chk("pos", {1'b0, r[6:0]}, {1'b0, line, page});
    send(1'b0, 8'h4e);
    rd_exp(1'b1, 8'h00, 8'h00); // dummy read after a column load
    rd_exp(1'b1, b0, 8'hff);
    rd_exp(1'b1, b1, 8'hff);
    send(1'b0, 8'h4e);
    send(1'b0, 8'he0); // no column load until the end command
    rd_exp(1'b1, 8'h00, 8'h00);
    rd_exp(1'b1, b0, 8'hff);
    send(1'b1, nb);
    rd_exp(1'b1, b0, 8'hff);
    rd_exp(1'b1, b1, 8'hff);
    send(1'b0, 8'hee);
    rd_exp(1'b1, 8'h00, 8'h00);
    rd_exp(1'b1, nb, 8'hff);
    send(1'b0, 8'he2);
    chk("pos", 8'h03, {1'b0, line, page});
    send(1'b0, 8'hb8 | {6'h00, r[1:0]});
    send(1'b0, 8'h4e);
    rd_exp(1'b1, 8'h00, 8'h00);
    rd_exp(1'b1, nb, 8'hff);
    @(posedge i_clk_sys);
    hw_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    hw_rst <= 1'b0;
    rd_exp(1'b0, 8'h90, 8'h90);
    idle();
    chk("pos", 8'h03, {1'b0, line, page});
    repeat (2) @(posedge i_clk_sys);
    tally_and_finish();
  end
endmodule // lcd_driver_command_decoder_tb
bind lcdcd_decoder lcdcd_properties i_lcdcd_properties (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_command_data_select(i_command_data_select), .i_rd(i_rd), .i_wr(i_wr), .o_data(o_data),
  .o_data_valid(o_data_valid), .o_wr_ready(o_wr_ready), .o_seg_dir_normal(o_seg_dir_normal),
  .o_display_on(o_display_on), .o_static_drive(o_static_drive), .o_power_save(o_power_save),
  .o_osc_out_oe_n(o_osc_out_oe_n));
`default_nettype wire
